/* bench/tb_top.sv */
// Bench for the test-pin mux and reset-mode block.
// Assumes tpm_pkg and the scan tester model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tpm_pkg::*;
  logic clk, rst_n, sel, rin_n, flt_n, trst, dbg, tck, s_ir, s_dr, s_by, b_ir, b_by, b_bs;
  logic scan_rst_n, so, soe, core_rst_n, ref_rst_n, mst;
  logic [7:0] core_oe, pin_oe;
  logic [1:0] ras_d, ras;
  logic [3:0] cas_d, cas;
  int fails = 0;
  int n_checks = 0;
  tpm_top #(.N_OUT(8), .N_RAS(2), .N_CAS(4)) u_tpm_top (.CLK(clk), .RST_N(rst_n), .TCK(tck),
    .PORT_FUNCTION_SELECT(sel), .RESET_IN_N(rin_n), .FORCE_FLOAT_N(flt_n), .TRST_DEBUG_SERIAL_CLOCK_PIN(trst),
    .SCAN_SHIFT_IR(s_ir), .SCAN_SHIFT_DR(s_dr), .SCAN_IR_BYPASS(s_by), .IR_SERIAL(b_ir),
    .BYPASS_SERIAL(b_by), .BSR_SERIAL(b_bs), .SCAN_RESET_N(scan_rst_n), .DEBUG_SERIAL_OUT_D(dbg),
    .SER_PIN_O(so), .SER_PIN_OE(soe), .CORE_OE(core_oe), .PIN_OE(pin_oe), .RAS_N_D(ras_d),
    .CAS_N_D(cas_d), .RAS_N(ras), .CAS_N(cas), .CORE_RESET_N(core_rst_n),
    .REFRESH_RESET_N(ref_rst_n), .MASTER_RESET(mst));
  tpm_scan_host u_tpm_scan_host (.TCK(tck), .SH_IR(s_ir), .SH_DR(s_dr), .BYP(s_by),
    .B_IR(b_ir), .B_BYP(b_by), .B_BSR(b_bs));
  // Processor clock, 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compares a value of up to eight bits.
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Board pins change, then three edges through sync and flop, one spare.
  task automatic pins(input logic r, f);
    @(posedge clk);
    rin_n <= r;
    flt_n <= f;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_modes;
    pins(1'b0, 1'b0);
    chk({mst, ref_rst_n, core_rst_n}, 3'h4);
    chk({ras, cas}, 6'h3f);
    pins(1'b0, 1'b1);
    chk({mst, ref_rst_n, core_rst_n}, 3'h2);
    chk({ras, cas}, 6'h15);
    @(posedge clk);
    ras_d <= 2'b10;
    cas_d <= 4'b1010;
    @(posedge clk);
    #1;
    chk({ras, cas}, 6'h2a);
    pins(1'b1, 1'b1);
    chk({mst, ref_rst_n, core_rst_n}, 3'h3);
    $display("t_modes done");
  endtask
  // Float acts without a clock edge and spares the scan pin.
  task automatic t_float;
    @(posedge clk);
    core_oe <= 8'ha5;
    #1;
    chk(pin_oe, 8'ha5);
    @(posedge clk);
    flt_n <= 1'b0;
    #1;
    chk(pin_oe, 8'h00);
    u_tpm_scan_host.shift(1'b0, 1'b1, 1'b0, 1'b1);
    chk({soe, so}, 2'h3);
    @(posedge clk);
    flt_n <= 1'b1;
    $display("t_float done");
  endtask
  task automatic scan1(input logic ir, dr, by, b);
    u_tpm_scan_host.shift(ir, dr, by, b);
    chk({soe, so}, {1'b1, b});
  endtask
  task automatic t_scan;
    scan1(1'b1, 1'b0, 1'b0, 1'b1);
    scan1(1'b0, 1'b1, 1'b1, 1'b0);
    scan1(1'b0, 1'b1, 1'b0, 1'b1);
    scan1(1'b1, 1'b1, 1'b0, 1'b0);
    u_tpm_scan_host.shift(1'b0, 1'b0, 1'b0, 1'b1);
    chk(soe, 1'b0);
    scan1(1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    trst <= 1'b0;
    #1;
    chk({soe, scan_rst_n}, 2'h0);
    @(posedge clk);
    trst <= 1'b1;
    $display("t_scan done");
  endtask
  // Select changes only inside reset.
  task automatic t_debug;
    pins(1'b0, 1'b1);
    @(posedge clk);
    sel <= FUNC_DEBUG;
    pins(1'b1, 1'b1);
    @(posedge clk);
    dbg <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({soe, so}, 2'h3);
    @(posedge clk);
    dbg <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({soe, so}, 2'h2);
    $display("t_debug done");
  endtask
  // Power-on is master reset with a test reset pulse, select in scan use.
  // The pulse clears the scan output stage, which would otherwise stay unknown until the first shift.
  initial begin
    {rst_n, rin_n, flt_n, dbg, sel} = 5'h0;
    trst = 1'b1;
    core_oe = 8'h00;
    ras_d = 2'b01;
    cas_d = 4'b0101;
    repeat (3) @(posedge clk);
    trst <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    trst <= 1'b1;
    t_modes;
    t_float;
    t_scan;
    t_debug;
    end_sim;
  end
  // Cuts a hang short.
  initial begin
    #200000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire

/* bench/tpm_scan_host.sv */
// Scan tester model: test clock, scan state and serial bits.
// Assumes the bench calls shift() while the pins are in scan use.
`timescale 1ns/10ps
`default_nettype none
module tpm_scan_host (
  // Test clock and scan state.
  output logic TCK,
  output logic SH_IR,
  output logic SH_DR,
  output logic BYP,
  // Serial bits of the three registers.
  output logic B_IR,
  output logic B_BYP,
  output logic B_BSR
);
  // Unchosen sources carry the inverse, so a wrong pick shows.
  task automatic set(input logic ir, dr, by, b);
    SH_IR = ir;
    SH_DR = dr;
    BYP = by;
    B_IR = ir ? b : ~b;
    B_BYP = (!ir && by) ? b : ~b;
    B_BSR = (!ir && !by) ? b : ~b;
  endtask
  // The clock stands low between frames.
  initial begin
    TCK = 1'b0;
    set(1'b0, 1'b0, 1'b0, 1'b0);
  end
  // One cycle: bits change after the rise, the pin updates on the fall.
  task automatic shift(input logic ir, dr, by, b);
    TCK = 1'b1;
    set(ir, dr, by, b);
    #62.5;
    TCK = 1'b0;
    #62.5;
  endtask
endmodule
`default_nettype wire

/* common/tpm_pkg.sv */
// Constants shared by the test-pin mux and reset-mode block.
// Assumes nothing beyond a SystemVerilog compiler.
package tpm_pkg;

  // Function-select codes for the shared serial pins.
  localparam logic FUNC_SCAN = 1'b0;
  localparam logic FUNC_DEBUG = 1'b1;

  // Values after reset.
  localparam logic TDO_RST = 1'b0;
  localparam logic TDO_OE_RST = 1'b0;
  localparam logic DSO_RST = 1'b0;
  localparam logic STROBE_NEGATED = 1'b1;
  localparam logic SYNC_RST = 1'b0; // Reads as reset and float asserted until the pins have passed both synchroniser stages.

  // Default widths of the gated output group and memory strobes.
  localparam int OUT_COUNT = 8;
  localparam int ROW_STROBES = 2;
  localparam int COL_STROBES = 4;

  // Reset modes decoded from the reset and float inputs.
  typedef enum logic [2:0] {
    RMODE_RUN = 3'b001,
    RMODE_NORMAL = 3'b010,
    RMODE_MASTER = 3'b100
  } tpm_rmode_t;

endpackage

/* hw/tpm_top.sv */
// Test-pin mux, scan data output stage and reset-mode decode.
// Assumes the scan state machine, instruction register and debug module sit outside and
// present their serial bits here; board pins are asynchronous to CLK.
//
// Notes on behaviour
// - Select 0 gives scan output, 1 debug.
// - Scan output updates on falling test clock.
// - Scan state and instruction choose output bit.
// - Scan output floats when not shifting.
// - Float input three-states the ordinary outputs, clocklessly.
// - Float spares scan pin; test reset floats it.
// - Reset plus float gives master reset.
// - Reset alone keeps refresh generator running.
// - Memory strobes negated only in master reset.
`timescale 1ns/10ps
`default_nettype none

module tpm_top #(
  parameter int N_OUT = tpm_pkg::OUT_COUNT,
  parameter int N_RAS = tpm_pkg::ROW_STROBES,
  parameter int N_CAS = tpm_pkg::COL_STROBES
) (
  // Processor clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Scan test clock.
  input wire logic TCK,
  // Board pins.
  input wire logic PORT_FUNCTION_SELECT,
  input wire logic RESET_IN_N,
  input wire logic FORCE_FLOAT_N,
  input wire logic TRST_DEBUG_SERIAL_CLOCK_PIN,
  // Scan logic, on the test clock.
  input wire logic SCAN_SHIFT_IR,
  input wire logic SCAN_SHIFT_DR,
  input wire logic SCAN_IR_BYPASS,
  input wire logic IR_SERIAL,
  input wire logic BYPASS_SERIAL,
  input wire logic BSR_SERIAL,
  output logic SCAN_RESET_N,
  // Debug module, on the processor clock.
  input wire logic DEBUG_SERIAL_OUT_D,
  // Shared serial output pin.
  output logic SER_PIN_O,
  output logic SER_PIN_OE,
  // Ordinary output drivers.
  input wire logic [N_OUT-1:0] CORE_OE,
  output logic [N_OUT-1:0] PIN_OE,
  // Memory strobes, active low.
  input wire logic [N_RAS-1:0] RAS_N_D,
  input wire logic [N_CAS-1:0] CAS_N_D,
  output logic [N_RAS-1:0] RAS_N,
  output logic [N_CAS-1:0] CAS_N,
  // Reset controls.
  output logic CORE_RESET_N,
  output logic REFRESH_RESET_N,
  output logic MASTER_RESET
);
  import tpm_pkg::*;

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sel_ff;
  logic rst_in_s_n;
  logic float_s_n;
  logic trst_n;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic nxt_tdo;
  logic dso_ff;
  tpm_rmode_t nxt_mode;

  // Test reset only exists while the shared pin is in scan use; it is asynchronous by nature.
  assign trst_n = TRST_DEBUG_SERIAL_CLOCK_PIN | PORT_FUNCTION_SELECT;
  assign SCAN_RESET_N = trst_n;

  // Two-stage synchronisers for select, reset and float pins.
  // They reset to asserted, so no run pulse leaks out while they fill after reset.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1_ff <= {3{SYNC_RST}};
      sync2_ff <= {3{SYNC_RST}};
    end else begin
      sync1_ff <= {PORT_FUNCTION_SELECT, RESET_IN_N, FORCE_FLOAT_N};
      sync2_ff <= sync1_ff;
    end
  end

  assign sel_ff = sync2_ff[2];
  assign rst_in_s_n = sync2_ff[1];
  assign float_s_n = sync2_ff[0];

  // Scan bit chosen from the shift state and held instruction.
  always_comb begin
    nxt_tdo = tdo_ff;
    if (SCAN_SHIFT_IR) begin
      nxt_tdo = IR_SERIAL;
    end else if (SCAN_SHIFT_DR) begin
      nxt_tdo = SCAN_IR_BYPASS ? BYPASS_SERIAL : BSR_SERIAL;
    end
  end

  // The scan output changes on the falling edge so the tester samples a settled bit.
  always_ff @(negedge TCK or negedge trst_n) begin
    if (!trst_n) begin
      tdo_ff <= TDO_RST;
    end else begin
      tdo_ff <= nxt_tdo;
    end
  end

  // Drive the scan pin only while shifting, so several devices can share the line.
  always_ff @(negedge TCK or negedge trst_n) begin
    if (!trst_n) begin
      tdo_oe_ff <= TDO_OE_RST;
    end else begin
      tdo_oe_ff <= SCAN_SHIFT_IR | SCAN_SHIFT_DR;
    end
  end

  // Debug serial output retimed on the processor clock.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dso_ff <= DSO_RST;
    end else begin
      dso_ff <= DEBUG_SERIAL_OUT_D;
    end
  end

  // Pin mux; the float input is left out here on purpose, and test reset floats scan use.
  always_comb begin
    if (sel_ff == FUNC_DEBUG) begin
      SER_PIN_O = dso_ff;
      SER_PIN_OE = 1'b1;
    end else begin
      SER_PIN_O = tdo_ff;
      SER_PIN_OE = tdo_oe_ff & trst_n;
    end
  end

  // Float gating needs no clock edge, so it works with the processor clock stopped.
  assign PIN_OE = CORE_OE & {N_OUT{FORCE_FLOAT_N}};

  // Reset mode decode from synchronised pins.
  always_comb begin
    if (!rst_in_s_n && !float_s_n) begin
      nxt_mode = RMODE_MASTER;
    end else if (!rst_in_s_n) begin
      nxt_mode = RMODE_NORMAL;
    end else begin
      nxt_mode = RMODE_RUN;
    end
  end

  // Reset outputs; the refresh generator is only reset by master reset.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CORE_RESET_N <= 1'b0;
      REFRESH_RESET_N <= 1'b0;
      MASTER_RESET <= 1'b1;
    end else begin
      CORE_RESET_N <= (nxt_mode == RMODE_RUN);
      REFRESH_RESET_N <= (nxt_mode != RMODE_MASTER);
      MASTER_RESET <= (nxt_mode == RMODE_MASTER);
    end
  end

  // Strobes pass through except in master reset, so refresh survives a normal reset.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RAS_N <= {N_RAS{STROBE_NEGATED}};
      CAS_N <= {N_CAS{STROBE_NEGATED}};
    end else if (nxt_mode == RMODE_MASTER) begin
      RAS_N <= {N_RAS{STROBE_NEGATED}};
      CAS_N <= {N_CAS{STROBE_NEGATED}};
    end else begin
      RAS_N <= RAS_N_D;
      CAS_N <= CAS_N_D;
    end
  end

  // Checks on the processor clock.
  sel_debug_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sel_ff == FUNC_DEBUG) |-> (SER_PIN_O == dso_ff) && SER_PIN_OE)
    else $error("Debug select does not route debug output.");
  sel_scan_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sel_ff == FUNC_SCAN) |-> (SER_PIN_O == tdo_ff))
    else $error("Scan select does not route scan output.");
  float_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !FORCE_FLOAT_N |-> (PIN_OE == '0))
    else $error("Output driven while float asserted.");
  float_comb_a: assert property (@(posedge CLK) disable iff (!RST_N)
    FORCE_FLOAT_N |-> (PIN_OE == CORE_OE))
    else $error("Output enable not passed while float negated.");
  trst_float_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (sel_ff == FUNC_SCAN && !trst_n) |-> !SER_PIN_OE)
    else $error("Scan pin driven during test reset.");
  master_rst_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!rst_in_s_n && !float_s_n) |=> MASTER_RESET && !REFRESH_RESET_N && !CORE_RESET_N)
    else $error("Master reset not entered.");
  normal_rst_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!rst_in_s_n && float_s_n) |=> !CORE_RESET_N && REFRESH_RESET_N && !MASTER_RESET)
    else $error("Normal reset reset the refresh generator.");
  strobe_neg_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MASTER_RESET |-> (&RAS_N) && (&CAS_N))
    else $error("Strobe asserted during master reset.");
  strobe_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!rst_in_s_n && float_s_n) |=> (RAS_N == $past(RAS_N_D)) && (CAS_N == $past(CAS_N_D)))
    else $error("Strobe disturbed during normal reset.");

  // Checks on the falling test clock.
  tdo_ir_a: assert property (@(negedge TCK) disable iff (!trst_n)
    SCAN_SHIFT_IR |=> (tdo_ff == $past(IR_SERIAL)) && tdo_oe_ff)
    else $error("Instruction bit not shifted out.");
  tdo_dr_a: assert property (@(negedge TCK) disable iff (!trst_n)
    (SCAN_SHIFT_DR && !SCAN_SHIFT_IR) |=>
      (tdo_ff == ($past(SCAN_IR_BYPASS) ? $past(BYPASS_SERIAL) : $past(BSR_SERIAL))))
    else $error("Wrong data register on scan output.");
  tdo_idle_a: assert property (@(negedge TCK) disable iff (!trst_n)
    !(SCAN_SHIFT_IR || SCAN_SHIFT_DR) |=> !tdo_oe_ff && $stable(tdo_ff))
    else $error("Scan output driven while idle.");

  // Main scenarios.
  master_seen_c: cover property (@(posedge CLK) disable iff (!RST_N) MASTER_RESET ##1 !MASTER_RESET);
  normal_seen_c: cover property (@(posedge CLK) disable iff (!RST_N) !CORE_RESET_N && REFRESH_RESET_N);
  debug_use_c: cover property (@(posedge CLK) disable iff (!RST_N) (sel_ff == FUNC_DEBUG) && SER_PIN_O);
  shift_dr_c: cover property (@(negedge TCK) disable iff (!trst_n) SCAN_SHIFT_DR [*3]);

endmodule

`default_nettype wire
